// *** logic/dsna_top.sv ***
// status lamps, node address capture and 7-segment display of a fieldbus servo drive
// assumes bus state, error causes, codes and chain position come from logic on sys_clk_i;
// switches and phy link/activity lines are asynchronous pins
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module dsna_top
   import dsna_pkg::*;
#(
   parameter int TICK_CYC      = TICK_CYC_DEF,
   parameter int SETTLE_CYC    = SETTLE_CYC_DEF,
   parameter int ADDR_SHOW_CYC = ADDR_SHOW_CYC_DEF
) (
   input  wire logic            sys_clk_i,
   input  wire logic            rst_n_i,
   // register port
   input  wire logic [7:0]      reg_addr_i,
   input  wire logic [31:0]     reg_wdata_i,
   input  wire logic            reg_we_i,
   input  wire logic            reg_re_i,
   output logic [31:0]          reg_rdata_o,
   output logic                 irq_o,
   // switch pins
   input  wire logic [3:0]      units_digit_switch_i,
   input  wire logic [3:0]      tens_digit_switch_i,
   // automatic addressing
   input  wire logic [6:0]      chain_position_i,
   input  wire logic            chain_position_valid_i,
   // fieldbus status
   input  dsna_bus_state_t      bus_state_i,
   input  dsna_err_t            err_cause_i,
   // phy pins, [0] input port, [1] output port
   input  wire logic [1:0]      link_up_i,
   input  wire logic [1:0]      link_act_i,
   // display sources
   input  wire logic [7:0]      monitor_value_i,
   input  wire logic            err_active_i,
   input  wire logic [7:0]      err_code_i,
   input  wire logic            warn_active_i,
   input  wire logic [7:0]      warn_code_i,
   // outputs
   output dsna_led_t            led_o,
   output dsna_seg_t            seg_o,
   output logic [6:0]           node_address_o,
   output logic                 node_address_valid_o
);

   typedef enum logic [1:0] {AS_SETTLE, AS_WAIT_AUTO, AS_SHOW, AS_RUN} dsna_addr_state_t;

   // pin synchronisers
   logic [3:0] units_m_q;
   logic [3:0] units_s_q;
   logic [3:0] tens_m_q;
   logic [3:0] tens_s_q;
   logic [1:0] up_m_q;
   logic [1:0] up_s_q;
   logic [1:0] act_m_q;
   logic [1:0] act_s_q;
   logic [1:0] up_d1_q;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         units_m_q <= 4'h0;
         units_s_q <= 4'h0;
         tens_m_q  <= 4'h0;
         tens_s_q  <= 4'h0;
         up_m_q    <= 2'h0;
         up_s_q    <= 2'h0;
         act_m_q   <= 2'h0;
         act_s_q   <= 2'h0;
         up_d1_q   <= 2'h0;
      end else begin
         units_m_q <= units_digit_switch_i;
         units_s_q <= units_m_q;
         tens_m_q  <= tens_digit_switch_i;
         tens_s_q  <= tens_m_q;
         up_m_q    <= link_up_i;
         up_s_q    <= up_m_q;
         act_m_q   <= link_act_i;
         act_s_q   <= act_m_q;
         up_d1_q   <= up_s_q;
      end
   end

   // node address capture
   dsna_addr_state_t as_q;
   dsna_addr_state_t as_d;
   logic [31:0]      cnt_q;
   logic [6:0]       addr_q;
   logic             auto_q;

   // digits above 9 are not clamped, so a bad setting can read past 99
   wire        sw_zero_w   = (units_s_q == DIGIT_ZERO) && (tens_s_q == DIGIT_ZERO);
   wire [6:0]  sw_addr_w   = 7'(tens_s_q) * 7'h0A + 7'(units_s_q);
   wire [7:0]  pos_plus_w  = {1'b0, chain_position_i} + 8'h01;
   // saturate rather than wrap, so a long chain never lands back on a low address
   wire [6:0]  auto_addr_w = (pos_plus_w > {1'b0, ADDR_MAX}) ? ADDR_MAX : pos_plus_w[6:0];
   wire        settle_w    = (as_q == AS_SETTLE) && (cnt_q == 32'(SETTLE_CYC - 1));
   wire        show_end_w  = (as_q == AS_SHOW) && (cnt_q == 32'(ADDR_SHOW_CYC - 1));
   wire        take_sw_w   = settle_w && !sw_zero_w;
   wire        take_auto_w = (as_q == AS_WAIT_AUTO) && chain_position_valid_i;
   wire        latch_w     = take_sw_w || take_auto_w;

   // settling lets the synchronised digits land before the single capture
   always_comb begin
      as_d = as_q;
      unique case (as_q)
         AS_SETTLE:    if (settle_w) as_d = sw_zero_w ? AS_WAIT_AUTO : AS_SHOW;
         AS_WAIT_AUTO: if (take_auto_w) as_d = AS_SHOW;
         AS_SHOW:      if (show_end_w) as_d = AS_RUN;
         AS_RUN:       as_d = AS_RUN;
      endcase
   end

   // capture happens once per reset; AS_RUN never returns, so later switch moves are ignored
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         as_q   <= AS_SETTLE;
         cnt_q  <= 32'h0000_0000;
         addr_q <= 7'h00;
         auto_q <= 1'b0;
      end else begin
         as_q  <= as_d;
         // each phase times from zero because the counter restarts on a state change
         cnt_q <= (as_d != as_q) ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
         if (take_sw_w) begin
            addr_q <= sw_addr_w;
         end
         if (take_auto_w) begin
            addr_q <= auto_addr_w;
            auto_q <= 1'b1;
         end
      end
   end

   // the address counts as valid from the show phase on, never before capture
   wire addr_valid_w = (as_q == AS_SHOW) || (as_q == AS_RUN);

   // lamps
   dsna_pat_t pat_w;
   dsna_led_t led_q;

   dsna_pattern #(
      .TICK_CYC (TICK_CYC)
   ) u_pattern (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .pat_o     (pat_w)
   );

   // lamp decodes stay combinational; led_q below adds the one output flop
   logic run_w;
   logic err_w;

   always_comb begin
      run_w = 1'b0;
      unique case (bus_state_i)
         BS_INIT:   run_w = 1'b0;
         BS_PREOP:  run_w = pat_w.blink;
         BS_SAFEOP: run_w = pat_w.single;
         BS_OP:     run_w = 1'b1;
      endcase
   end

   // most severe cause wins when several are present at once
   always_comb begin
      if (err_cause_i.pdi_wdt) begin
         err_w = 1'b1;
      end else if (err_cause_i.boot) begin
         err_w = pat_w.flicker;
      end else if (err_cause_i.app_wdt) begin
         err_w = pat_w.dbl;
      end else if (err_cause_i.sync || err_cause_i.data) begin
         err_w = pat_w.single;
      end else if (err_cause_i.setting) begin
         err_w = pat_w.blink;
      end else begin
         err_w = 1'b0;
      end
   end

   dsna_led_t led_d;
   // both ports share one flicker phase from the common timebase
   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : g_link
         // activity is level-sampled; bursts shorter than one clock may be missed
         assign led_d.link[p] = up_s_q[p] & (act_s_q[p] ? pat_w.flicker : 1'b1);
      end
   endgenerate
   assign led_d.run = run_w;
   assign led_d.err = err_w;
   // every lamp leaves through one flop so the pins never glitch

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         led_q <= '0;
      end else begin
         led_q <= led_d;
      end
   end

   // registers
   logic [1:0]       disp_sel_q;
   logic [IRQ_W-1:0] irq_stat_q;
   logic [IRQ_W-1:0] irq_en_q;
   logic [31:0]      rdata_q;
   logic             err_d1_q;
   logic             warn_d1_q;

   // writes to read-only offsets fall through every decode and are lost
   wire wr_ctrl_w = reg_we_i && (reg_addr_i == REG_CTRL);
   wire wr_clr_w  = reg_we_i && (reg_addr_i == REG_IRQ_CLR);
   wire wr_en_w   = reg_we_i && (reg_addr_i == REG_IRQ_EN);

   // [3] link change, [2] warning rose, [1] error rose, [0] address latched
   wire [IRQ_W-1:0] irq_ev_w = {
      |(up_s_q ^ up_d1_q),
      warn_active_i & ~warn_d1_q,
      err_active_i & ~err_d1_q,
      latch_w
   };
   wire [IRQ_W-1:0] irq_clr_w = wr_clr_w ? reg_wdata_i[IRQ_W-1:0] : '0;

   wire [31:0] status_w = {20'h00000, bus_state_i, auto_q, addr_valid_w, 1'b0, addr_q};
   // unmapped offsets and the write-only clear read as zero
   logic [31:0] rd_mux_w;
   always_comb begin
      rd_mux_w = 32'h0000_0000;
      unique case (reg_addr_i)
         REG_CTRL:     rd_mux_w = {DISP_SEL_INDEX, 14'h0000, disp_sel_q};
         REG_STATUS:   rd_mux_w = status_w;
         REG_IRQ_STAT: rd_mux_w = {28'h0000000, irq_stat_q};
         REG_IRQ_EN:   rd_mux_w = {28'h0000000, irq_en_q};
         default:      rd_mux_w = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         disp_sel_q <= DISP_SEL_RST;
         irq_stat_q <= '0;
         irq_en_q   <= '0;
         rdata_q    <= 32'h0000_0000;
         err_d1_q   <= 1'b0;
         warn_d1_q  <= 1'b0;
      end else begin
         if (wr_ctrl_w) begin
            disp_sel_q <= reg_wdata_i[1:0];
         end
         if (wr_en_w) begin
            irq_en_q <= reg_wdata_i[IRQ_W-1:0];
         end
         // a new event in the clearing cycle survives the clear
         irq_stat_q <= (irq_stat_q & ~irq_clr_w) | irq_ev_w;
         // read data stands for one cycle only and is zero otherwise
         rdata_q    <= reg_re_i ? rd_mux_w : 32'h0000_0000;
         err_d1_q   <= err_active_i;
         warn_d1_q  <= warn_active_i;
      end
   end

   // 7-segment display
   // error beats warning beats the selected content; otherwise blank before an address is latched and for selections 2 and 3
   dsna_seg_t seg_q;
   dsna_seg_t seg_d;
   wire [3:0] addr_tens_w  = 4'(addr_q / 7'h0A);
   wire [3:0] addr_units_w = 4'(addr_q % 7'h0A);

   always_comb begin
      seg_d.tens  = SEG_BLANK;
      seg_d.units = SEG_BLANK;
      if (err_active_i) begin
         seg_d.tens  = dsna_seg7(err_code_i[7:4]);
         seg_d.units = dsna_seg7(err_code_i[3:0]);
      end else if (warn_active_i) begin
         seg_d.tens  = dsna_seg7(warn_code_i[7:4]);
         seg_d.units = dsna_seg7(warn_code_i[3:0]);
      end else if (as_q == AS_SHOW ||
                   (as_q == AS_RUN && disp_sel_q == DISP_SEL_ADDR)) begin
         seg_d.tens  = dsna_seg7(addr_tens_w);
         seg_d.units = dsna_seg7(addr_units_w);
      end else if (as_q == AS_RUN && disp_sel_q == DISP_SEL_MON) begin
         seg_d.tens  = dsna_seg7(monitor_value_i[7:4]);
         seg_d.units = dsna_seg7(monitor_value_i[3:0]);
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         seg_q <= '0;
      end else begin
         seg_q <= seg_d;
      end
   end

   assign reg_rdata_o          = rdata_q;
   assign irq_o                = |(irq_stat_q & irq_en_q);
   assign led_o                = led_q;
   assign seg_o                = seg_q;
   assign node_address_o       = addr_q;
   assign node_address_valid_o = addr_valid_w;

endmodule

// *** logic/dsna_pkg.sv ***
// constants, types and helpers shared by the drive status and node address block
// assumes a single 200 MHz clock and an asynchronous active-low reset
// Operation
// - green run lamp: off Init, blink Pre-Op, single flash Safe-Op, on Op.
// - red lamp: off, blink setting, flash sync/data, double app WDT, flicker boot, on PDI.
// - sync failure or corrupt data shows single flash, distinct from setting error blink.
// - per port link lamp: off no link, on linked, flickering with traffic.
// - node address comes from units and tens decimal switches, 00 to 99.
// - switches at 00 take chain position address, counted from 1.
// - switches are sampled once at power-up; later changes are ignored.
// - display shows node address at power-up, then content chosen at index 3700h.
// - display shows error code while error active, warning code while warning active.
package dsna_pkg;

   localparam int CLK_MHZ          = 200;
   localparam int TICK_MS          = 50;
   localparam int TICK_CYC_DEF     = TICK_MS * CLK_MHZ * 1000;
   localparam int SETTLE_US        = 1000;
   localparam int SETTLE_CYC_DEF   = SETTLE_US * CLK_MHZ;
   localparam int ADDR_SHOW_MS     = 2000;
   localparam int ADDR_SHOW_CYC_DEF = ADDR_SHOW_MS * CLK_MHZ * 1000;

   // pattern frame in timebase ticks
   localparam logic [4:0] FRAME_LAST  = 5'h17;
   localparam logic [4:0] FLASH_ON    = 5'h04;
   localparam logic [4:0] DBL_OFF_END = 5'h08;
   localparam logic [4:0] DBL_ON2_END = 5'h0C;
   localparam int         BLINK_BIT   = 2;

   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_CLR  = 8'h0C;
   localparam logic [7:0] REG_IRQ_EN   = 8'h10;

   localparam logic [15:0] DISP_SEL_INDEX = 16'h3700;
   localparam logic [1:0]  DISP_SEL_RST   = 2'h0;
   localparam logic [1:0]  DISP_SEL_ADDR  = 2'h0;
   localparam logic [1:0]  DISP_SEL_MON   = 2'h1;

   localparam int IRQ_W       = 4;
   localparam int IRQ_LATCHED = 0;
   localparam int IRQ_ERR     = 1;
   localparam int IRQ_WARN    = 2;
   localparam int IRQ_LINK    = 3;

   localparam logic [6:0] ADDR_MAX   = 7'h63;
   localparam logic [6:0] SEG_BLANK  = 7'h00;
   localparam logic [3:0] DIGIT_ZERO = 4'h0;

   typedef enum logic [1:0] {BS_INIT, BS_PREOP, BS_SAFEOP, BS_OP} dsna_bus_state_t;

   typedef struct packed {
      logic setting;
      logic sync;
      logic data;
      logic app_wdt;
      logic boot;
      logic pdi_wdt;
   } dsna_err_t;

   typedef struct packed {
      logic flicker;
      logic blink;
      logic single;
      logic dbl;
   } dsna_pat_t;

   typedef struct packed {
      logic       run;
      logic       err;
      logic [1:0] link;   // [0] input port, [1] output port
   } dsna_led_t;

   typedef struct packed {
      logic [6:0] tens;
      logic [6:0] units;
   } dsna_seg_t;

   // segments gfedcba, active high
   function automatic logic [6:0] dsna_seg7(input logic [3:0] v);
      logic [6:0] s;
      s = 7'h00;
      unique case (v)
         4'h0: s = 7'h3F;
         4'h1: s = 7'h06;
         4'h2: s = 7'h5B;
         4'h3: s = 7'h4F;
         4'h4: s = 7'h66;
         4'h5: s = 7'h6D;
         4'h6: s = 7'h7D;
         4'h7: s = 7'h07;
         4'h8: s = 7'h7F;
         4'h9: s = 7'h6F;
         4'hA: s = 7'h77;
         4'hB: s = 7'h7C;
         4'hC: s = 7'h39;
         4'hD: s = 7'h5E;
         4'hE: s = 7'h79;
         4'hF: s = 7'h71;
      endcase
      return s;
   endfunction

endpackage

// *** logic/dsna_pattern.sv ***
// shared lamp timebase: flicker, blink, single flash and double flash waveforms
// assumes the tick length is a whole number of clock cycles
`timescale 1ns/1ps
module dsna_pattern
   import dsna_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYC_DEF
) (
   input  wire logic      sys_clk_i,
   input  wire logic      rst_n_i,
   output dsna_pat_t      pat_o
);

   logic [31:0] tick_cnt_q;
   logic [4:0]  frame_q;
   logic        flick_q;
   dsna_pat_t   pat_q;

   wire tick_w      = (tick_cnt_q == 32'(TICK_CYC - 1));
   wire frame_end_w = (frame_q == FRAME_LAST);

   // one counter feeds every pattern so lamps on the same drive stay in phase
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_cnt_q <= 32'h0000_0000;
         frame_q    <= 5'h00;
         flick_q    <= 1'b0;
      end else begin
         tick_cnt_q <= tick_w ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
         if (tick_w) begin
            frame_q <= frame_end_w ? 5'h00 : frame_q + 5'h01;
            flick_q <= ~flick_q;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pat_q <= '0;
      end else begin
         pat_q.flicker <= flick_q;
         pat_q.blink   <= ~frame_q[BLINK_BIT];
         pat_q.single  <= (frame_q < FLASH_ON);
         pat_q.dbl     <= (frame_q < FLASH_ON) ||
                          (frame_q >= DBL_OFF_END && frame_q < DBL_ON2_END);
      end
   end

   assign pat_o = pat_q;

endmodule

// *** tb/dsna_top_properties.sv ***
// port assertions for the drive status and node address block
// assumes one clock domain; bound to every dsna_top instance
`timescale 1ns/1ps
module dsna_top_checker
   import dsna_pkg::*;
(
   input  wire logic       sys_clk_i,
   input  wire logic       rst_n_i,
   input  dsna_bus_state_t bus_state_i,
   input  dsna_err_t       err_cause_i,
   input  wire logic [1:0] link_up_i,
   input  wire logic [1:0] link_act_i,
   input  dsna_led_t       led_o,
   input  wire logic [6:0] node_address_o,
   input  wire logic       node_address_valid_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_run_op; bus_state_i == BS_OP |=> led_o.run; endproperty
   a_run_op: assert property (p_run_op)
      else $error("run lamp off in operational");
   property p_run_init; bus_state_i == BS_INIT |=> !led_o.run; endproperty
   a_run_init: assert property (p_run_init)
      else $error("run lamp lit in init");
   property p_err_pdi; err_cause_i.pdi_wdt |=> led_o.err; endproperty
   a_err_pdi: assert property (p_err_pdi)
      else $error("error lamp not steady on interface timeout");
   property p_err_none; err_cause_i == '0 |=> !led_o.err; endproperty
   a_err_none: assert property (p_err_none)
      else $error("error lamp lit without cause");
   // links pass a two-stage synchroniser, hence the four-cycle run-up
   property p_link_off; (!link_up_i[0]) [*4] |=> !led_o.link[0]; endproperty
   a_link_off: assert property (p_link_off)
      else $error("input link lamp lit without link");
   property p_link_on;
      (link_up_i[1] && !link_act_i[1]) [*4] |=> led_o.link[1];
   endproperty
   a_link_on: assert property (p_link_on)
      else $error("output link lamp not steady on idle link");
   property p_addr_hold;
      node_address_valid_o |=> node_address_valid_o && $stable(node_address_o);
   endproperty
   a_addr_hold: assert property (p_addr_hold)
      else $error("node address changed after capture");
   property p_addr_nz; node_address_valid_o |-> node_address_o != 7'h00; endproperty
   a_addr_nz: assert property (p_addr_nz)
      else $error("captured node address is zero");
   c_op: cover property (node_address_valid_o && bus_state_i == BS_OP);
   c_boot: cover property (err_cause_i.boot ##1 led_o.err);
   c_cap: cover property ($rose(node_address_valid_o));
endmodule

bind dsna_top dsna_top_checker chk_u (
   .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bus_state_i(bus_state_i),
   .err_cause_i(err_cause_i), .link_up_i(link_up_i), .link_act_i(link_act_i),
   .led_o(led_o), .node_address_o(node_address_o),
   .node_address_valid_o(node_address_valid_o)
);

// *** tb/dsna_master_model.sv ***
// fieldbus master stand-in: steps the bus state, offers a chain position late,
// and works out the axis number from the address the drive reports
`timescale 1ns/1ps
module dsna_master_model
   import dsna_pkg::*;
#(
   parameter int AXIS_OFFSET = 2,
   parameter int TAKEN_AXIS  = 6,
   parameter int CHAIN_POS   = 4,
   parameter int POS_DELAY   = 20
) (
   input  wire logic       sys_clk_i,
   input  wire logic       rst_n_i,
   input  dsna_bus_state_t target_state_i,
   input  wire logic [6:0] node_address_i,
   input  wire logic       node_address_valid_i,
   output dsna_bus_state_t bus_state_o,
   output logic [6:0]      chain_position_o,
   output logic            chain_position_valid_o,
   output logic [7:0]      axis_o,
   output logic            cfg_err_o
);
   int wait_q;
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_state_o <= BS_INIT;
         wait_q <= 0;
         chain_position_valid_o <= 1'b0;
      end else begin
         bus_state_o <= target_state_i;
         if (wait_q < POS_DELAY) wait_q <= wait_q + 1;
         chain_position_valid_o <= (wait_q == POS_DELAY);
      end
   end
   // position is garbage until offered, so an early sample shows up
   assign chain_position_o = chain_position_valid_o ? 7'(CHAIN_POS) : 7'(wait_q);
   // offset belongs to this interface only, addresses unique per interface
   assign axis_o = node_address_valid_i ?
                   8'(node_address_i) - 8'h01 + 8'(AXIS_OFFSET) : 8'h00;
   assign cfg_err_o = node_address_valid_i && (axis_o == 8'(TAKEN_AXIS));
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for dsna_top with short lamp, settle and display counts
// assumes the master model drives bus state and chain position
`timescale 1ns/1ps
module tb_top
   import dsna_pkg::*;
;
   logic            clk = 1'b0, rst_n = 1'b0, we = 1'b0, re = 1'b0;
   logic [7:0]      addr = '0, mon = '0, ecode = '0, wcode = '0;
   logic [31:0]     wd = '0, rdata;
   logic [3:0]      units = 4'h4, tens = 4'h3;
   logic [1:0]      up = '0, act = '0;
   logic            eact = 1'b0, wact = 1'b0, irq, cpv, nav, cerr;
   logic [6:0]      cpos, naddr;
   logic [7:0]      axis;
   dsna_bus_state_t tgt = BS_INIT, bst;
   dsna_err_t       err = '0;
   dsna_led_t       led;
   dsna_seg_t       seg;
   int              num_errors = 0, samples_checked = 0;
   logic [6:0] SEG [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
                            7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
   int RUN_ON [4] = '{0, 48, 16, 96}, RUN_RS [4] = '{0, 3, 1, 0};
   int ERR_ON [7] = '{48, 16, 16, 32, 48, 96, 0}, ERR_RS [7] = '{3, 1, 1, 2, 12, 0, 0};
   int LNK_ON [3] = '{0, 96, 48}, LNK_RS [3] = '{0, 0, 12};
   initial forever #2.5 clk = ~clk;
   dsna_top #(.TICK_CYC(4), .SETTLE_CYC(8), .ADDR_SHOW_CYC(50)) dut_u (
      .sys_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wd),
      .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .irq_o(irq),
      .units_digit_switch_i(units), .tens_digit_switch_i(tens),
      .chain_position_i(cpos), .chain_position_valid_i(cpv), .bus_state_i(bst),
      .err_cause_i(err), .link_up_i(up), .link_act_i(act), .monitor_value_i(mon),
      .err_active_i(eact), .err_code_i(ecode), .warn_active_i(wact),
      .warn_code_i(wcode), .led_o(led), .seg_o(seg), .node_address_o(naddr),
      .node_address_valid_o(nav));
   dsna_master_model mst_u (
      .sys_clk_i(clk), .rst_n_i(rst_n), .target_state_i(tgt), .node_address_i(naddr),
      .node_address_valid_i(nav), .bus_state_o(bst), .chain_position_o(cpos),
      .chain_position_valid_o(cpv), .axis_o(axis), .cfg_err_o(cerr));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1 check(rdata, exp);
      @(posedge clk);
      #1 check(rdata, 32'h0);
   endtask
   // one whole 96-cycle frame, so counts do not depend on phase
   task automatic lamp(input int sel, input int on_e, input int rs_e);
      int on_n, rs_n;
      logic prev;
      on_n = 0;
      rs_n = 0;
      repeat (8) @(posedge clk);
      #1 prev = led[sel];
      repeat (96) begin
         @(posedge clk);
         #1 if (led[sel] === 1'b1) on_n++;
         if (led[sel] === 1'b1 && prev !== 1'b1) rs_n++;
         prev = led[sel];
      end
      check(32'(on_n), 32'(on_e));
      check(32'(rs_n), 32'(rs_e));
   endtask
   task automatic restart();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (9) @(posedge clk);
      #1 check({irq, led, seg, naddr, nav}, 32'h0);
      check(rdata, 32'h0);
      @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 200 && nav !== 1'b1; i++) @(posedge clk);
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic end_of_test();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      num_errors++;
      end_of_test();
   end
   initial begin
      restart();
      check(naddr, 7'd34);
      check(axis, 8'd35);
      check(cerr, 1'b0);
      check(seg, {SEG[3], SEG[4]});
      rd(REG_STATUS, 32'h0000_0122);
      rd(REG_IRQ_STAT, 32'h1);
      check(irq, 1'b0);
      wr(REG_IRQ_EN, 32'h1);
      check(irq, 1'b1);
      wr(REG_IRQ_CLR, 32'h1);
      check(irq, 1'b0);
      rd(REG_IRQ_STAT, 32'h0);
      @(posedge clk);
      units <= 4'h7;
      tens <= 4'h7;
      repeat (60) @(posedge clk);
      check(naddr, 7'd34);
      wr(REG_CTRL, 32'h1);
      rd(REG_CTRL, 32'h3700_0001);
      rd(8'h20, 32'h0);
      @(posedge clk);
      mon <= 8'hA5;
      repeat (3) @(posedge clk);
      #1 check(seg, {SEG[10], SEG[5]});
      @(posedge clk);
      wact <= 1'b1;
      wcode <= 8'h1C;
      repeat (3) @(posedge clk);
      #1 check(seg, {SEG[1], SEG[12]});
      @(posedge clk);
      eact <= 1'b1;
      ecode <= 8'h2E;
      repeat (3) @(posedge clk);
      #1 check(seg, {SEG[2], SEG[14]});
      @(posedge clk);
      eact <= 1'b0;
      wact <= 1'b0;
      wr(REG_CTRL, 32'h2);
      @(posedge clk);
      #1 check(seg, 32'h0);
      wr(REG_CTRL, 32'h0);
      @(posedge clk);
      #1 check(seg, {SEG[3], SEG[4]});
      for (int s = 0; s < 4; s++) begin
         @(posedge clk);
         tgt <= dsna_bus_state_t'(s);
         lamp(3, RUN_ON[s], RUN_RS[s]);
      end
      for (int i = 0; i < 7; i++) begin
         @(posedge clk);
         err <= dsna_err_t'(6'h20 >> i);
         lamp(2, ERR_ON[i], ERR_RS[i]);
      end
      for (int p = 0; p < 2; p++) begin
         for (int m = 0; m < 3; m++) begin
            @(posedge clk);
            up[p] <= (m > 0);
            act[p] <= (m == 2);
            lamp(p, LNK_ON[m], LNK_RS[m]);
         end
      end
      rd(REG_IRQ_STAT, 32'hE);
      @(posedge clk);
      units <= 4'h0;
      tens <= 4'h0;
      restart();
      check(naddr, 7'd5);
      rd(REG_STATUS, 32'h0000_0F05);
      check(axis, 8'd6);
      check(cerr, 1'b1);
      end_of_test();
   end
endmodule
